// file: core/pacr_regs.sv
// phy port auto-negotiation, control and cable diagnostic registers on apb
//
// Overview of operation
// - two read-only identifier words return fixed halves of the phy identity code
// - advertise bit 10 pause, reset 1, shares storage with port control bit 4
// - advertise bits 8..5 give duplex abilities, reset 1, shared with control 3..0
// - advertise next-page, fault, reserved read zero; selector reads 0x01
// - partner bit 10 reports partner pause, reset 0
// - partner bits 8..5 report partner abilities, reset 0
// - partner bits 15..13 always zero; low five bits read 0x01
// - cable result: 00 normal, 01 open, 10 short, 11 test failed
// - writing 1 to bit 12 starts cable test; bit self-clears when done
// - nine-bit fault count gives distance to fault, about 0.4 m each
// - special bit 11, reset 0, forces link pass
// - special bit 9, reset 0, loops line receive back to transmit
// - control bit 15, reset 0, drives all four port leds high
// - control bit 14, reset 0, disables the port transmitter
// - control bit 13, reset 0, setting it restarts auto-negotiation
// - control bit 10, reset 0, disables automatic mdi/mdi-x crossover
// - control bit 9, reset 0, forces mdi-x only while crossover disabled
// - control bit 7, reset 1, enables negotiation; else bits 6,5 decide
// - control bit 6, reset 1, selects 100 or 10 when negotiation off
// - control bit 5, reset 1, full or half duplex when negotiation off/failed
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "pacr_params.svh"
module pacr_regs
  import pacr_pkg::*;
#(
  parameter int unsigned ADDR_W    = 12,
  parameter logic [15:0] ID_LOW    = 16'h5A3C, // arbitrary value
  parameter logic [15:0] ID_HIGH   = 16'h00A5, // arbitrary value
  parameter int unsigned LIMIT_CYC = `PACR_DIAG_LIMIT_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire pacr_abil_t        partner_in,
  input  wire logic [3:0]        led_in,
  input  wire logic              diag_done,
  input  wire logic [1:0]        diag_result,
  input  wire logic [8:0]        diag_count,
  output pacr_ctrl_t             ctrl,
  output pacr_abil_t             advertise,
  output pacr_abil_t             partner,
  output logic                   mdix_x_mode,
  output logic                   an_restart,
  output logic [3:0]             port_led,
  output logic                   diag_run
);

  // address compare against a register index (byte address = 4 * index)
  function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    idx_hit = (addr == ADDR_W'({idx, 2'b00}));
  endfunction

  // byte-lane merge of a 16-bit view with the write data
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    lane_merge[7:0]  = strb[0] ? wd[7:0]  : old[7:0];
    lane_merge[15:8] = strb[1] ? wd[15:8] : old[15:8];
  endfunction

  // storage: every aliased bit lives in exactly one of these flops
  pacr_ctrl_t  ctrl_reg;
  pacr_abil_t  adv_reg;
  pacr_abil_t  partner_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        mdix_x_reg;
  logic        restart_pulse_reg;
  logic [3:0]  led_reg;

  // cable test status from the sequencer
  logic        diag_busy;
  logic [1:0]  diag_res;
  logic [8:0]  diag_cnt;

  // apb phase decode; one wait state so read data come from a flop
  wire acc_first = psel & penable & ~pready_reg;
  wire acc_done  = psel & penable & pready_reg;
  wire wr_done   = acc_done & pwrite;

  // register selects
  wire sel_id_lo = idx_hit(paddr, `PACR_IDX_ID_LOW);
  wire sel_id_hi = idx_hit(paddr, `PACR_IDX_ID_HIGH);
  wire sel_adv   = idx_hit(paddr, `PACR_IDX_ADVERTISE);
  wire sel_lp    = idx_hit(paddr, `PACR_IDX_PARTNER);
  wire sel_sc    = idx_hit(paddr, `PACR_IDX_SPECIAL);
  wire sel_pc    = idx_hit(paddr, `PACR_IDX_PORT_CTRL);
  wire mapped    = sel_id_lo | sel_id_hi | sel_adv | sel_lp | sel_sc | sel_pc;

  // advertisement view: pause, abilities and constant selector only
  wire [15:0] adv_view = {5'h00, adv_reg.pause, 1'b0, adv_reg.abil, `PACR_SELECTOR};

  // partner view: unsupported upper bits are zero, low field constant
  wire [15:0] lp_view = {5'h00, partner_reg.pause, 1'b0, partner_reg.abil, `PACR_SELECTOR};

  // special control view; enable bit reads the live busy state
  wire [15:0] sc_view = {1'b0, diag_res, diag_busy, ctrl_reg.force_link, 1'b0,
                         ctrl_reg.remote_loop, diag_cnt};

  // port control view; low five bits are the advertisement flops
  wire [15:0] pc_view = {ctrl_reg.led_off, ctrl_reg.tx_disable, ctrl_reg.restart_bit, 2'b00,
                         ctrl_reg.mdix_auto_off, ctrl_reg.mdix_force, 1'b0, ctrl_reg.an_enable,
                         ctrl_reg.speed_100, ctrl_reg.full_duplex, adv_reg.pause,
                         adv_reg.abil};

  // write data merged per byte lane onto each writable view
  wire        wr_adv   = wr_done & sel_adv;
  wire        wr_sc    = wr_done & sel_sc;
  wire        wr_pc    = wr_done & sel_pc;
  wire [15:0] adv_wv   = lane_merge(adv_view, pwdata, pstrb);
  wire [15:0] sc_wv    = lane_merge(sc_view, pwdata, pstrb);
  wire [15:0] pc_wv    = lane_merge(pc_view, pwdata, pstrb);

  // test starts on a written one while idle; a written zero cannot abort it
  wire diag_start = wr_sc & pstrb[1] & sc_wv[`PACR_SC_TEST_EN] & ~diag_busy;

  // next values of the advertisement flops, reachable from two views
  pacr_abil_t adv_next;
  assign adv_next.pause = wr_adv ? adv_wv[`PACR_AB_PAUSE] :
                          wr_pc  ? pc_wv[`PACR_PC_ADV_PAUSE] : adv_reg.pause;
  assign adv_next.abil  = wr_adv ? adv_wv[`PACR_AB_ABIL_HI:`PACR_AB_ABIL_LO] :
                          wr_pc  ? pc_wv[`PACR_PC_ADV_ABIL_HI:`PACR_PC_ADV_ABIL_LO] :
                          adv_reg.abil;

  // next value of the control word; only writable bits are taken from the bus
  pacr_ctrl_t ctrl_next;
  assign ctrl_next.led_off       = wr_pc ? pc_wv[`PACR_PC_LED_OFF]    : ctrl_reg.led_off;
  assign ctrl_next.tx_disable    = wr_pc ? pc_wv[`PACR_PC_TX_DIS]     : ctrl_reg.tx_disable;
  assign ctrl_next.restart_bit   = wr_pc ? pc_wv[`PACR_PC_RESTART]    : ctrl_reg.restart_bit;
  assign ctrl_next.mdix_auto_off = wr_pc ? pc_wv[`PACR_PC_MDIX_DIS]   : ctrl_reg.mdix_auto_off;
  assign ctrl_next.mdix_force    = wr_pc ? pc_wv[`PACR_PC_MDIX_FORCE] : ctrl_reg.mdix_force;
  assign ctrl_next.an_enable     = wr_pc ? pc_wv[`PACR_PC_AN_EN]      : ctrl_reg.an_enable;
  assign ctrl_next.speed_100     = wr_pc ? pc_wv[`PACR_PC_SPEED]      : ctrl_reg.speed_100;
  assign ctrl_next.full_duplex   = wr_pc ? pc_wv[`PACR_PC_DUPLEX]     : ctrl_reg.full_duplex;
  assign ctrl_next.force_link    = wr_sc ? sc_wv[`PACR_SC_FORCE_LINK] : ctrl_reg.force_link;
  assign ctrl_next.remote_loop   = wr_sc ? sc_wv[`PACR_SC_REMOTE_LOOP] : ctrl_reg.remote_loop;

  // restart pulses on every written one; a stored one in an unwritten lane must not fire it
  wire restart_next = wr_pc & pstrb[1] & pwdata[`PACR_PC_RESTART];

  // mdi-x force only counts while automatic crossover is off
  wire mdix_x_next = ctrl_reg.mdix_auto_off & ctrl_reg.mdix_force;

  // leds are active low, so off means driven high
  wire [3:0] led_next = ctrl_reg.led_off ? 4'hF : led_in;

  // read mux; identifiers are constants, unmapped reads return zero
  wire [15:0] rd_view = sel_id_lo ? ID_LOW :
                        sel_id_hi ? ID_HIGH :
                        sel_adv   ? adv_view :
                        sel_lp    ? lp_view :
                        sel_sc    ? sc_view :
                        sel_pc    ? pc_view : 16'h0000;

  // apb answer: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= acc_first;
      pslverr_reg <= acc_first & ~mapped;
      if (acc_first) begin
        prdata_reg <= {16'h0000, rd_view};
      end
    end
  end

  // control flops with their documented reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg             <= '0;
      ctrl_reg.an_enable   <= `PACR_RST_AN_EN;
      ctrl_reg.speed_100   <= `PACR_RST_SPEED;
      ctrl_reg.full_duplex <= `PACR_RST_DUPLEX;
      adv_reg.pause        <= `PACR_RST_ADV_PAUSE;
      adv_reg.abil         <= `PACR_RST_ADV_ABIL;
    end else begin
      ctrl_reg <= ctrl_next;
      adv_reg  <= adv_next;
    end
  end

  // partner abilities sampled from the phy core; software cannot write them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_reg <= '0;
    end else begin
      partner_reg <= partner_in;
    end
  end

  // derived pin-side outputs, each from its own flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdix_x_reg        <= 1'b0;
      restart_pulse_reg <= 1'b0;
      led_reg           <= 4'h0;
    end else begin
      mdix_x_reg        <= mdix_x_next;
      restart_pulse_reg <= restart_next;
      led_reg           <= led_next;
    end
  end

  // cable test sequencer; result and count only move when the test ends
  pacr_cable_diag #(
    .LIMIT_CYC (LIMIT_CYC)
  ) u_diag (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (diag_start),
    .diag_done   (diag_done),
    .diag_result (diag_result),
    .diag_count  (diag_count),
    .busy        (diag_busy),
    .result      (diag_res),
    .count       (diag_cnt),
    .diag_run    (diag_run)
  );

  // outputs straight from flops
  assign pready      = pready_reg;
  assign prdata      = prdata_reg;
  assign pslverr     = pslverr_reg;
  assign ctrl        = ctrl_reg;
  assign advertise   = adv_reg;
  assign partner     = partner_reg;
  assign mdix_x_mode = mdix_x_reg;
  assign an_restart  = restart_pulse_reg;
  assign port_led    = led_reg;

endmodule

// file: core/pacr_params.svh
// offsets, bit positions, reset values and timing of the phy port register bank
`ifndef PACR_PARAMS_SVH
`define PACR_PARAMS_SVH

// register indices; byte address is four times the index
`define PACR_IDX_ID_LOW      8'hE8
`define PACR_IDX_ID_HIGH     8'hEA
`define PACR_IDX_ADVERTISE   8'hEC
`define PACR_IDX_PARTNER     8'hEE
`define PACR_IDX_SPECIAL     8'hF4
`define PACR_IDX_PORT_CTRL   8'hF6

// advertisement / partner ability layout
`define PACR_AB_PAUSE        10
`define PACR_AB_ABIL_HI      8
`define PACR_AB_ABIL_LO      5
`define PACR_AB_SEL_HI       4
`define PACR_AB_SEL_LO       0
`define PACR_SELECTOR        5'h01

// special control / cable diagnostic layout
`define PACR_SC_RES_HI       14
`define PACR_SC_RES_LO       13
`define PACR_SC_TEST_EN      12
`define PACR_SC_FORCE_LINK   11
`define PACR_SC_REMOTE_LOOP  9
`define PACR_SC_CNT_HI       8
`define PACR_SC_CNT_LO       0

// port control layout
`define PACR_PC_LED_OFF      15
`define PACR_PC_TX_DIS       14
`define PACR_PC_RESTART      13
`define PACR_PC_MDIX_DIS     10
`define PACR_PC_MDIX_FORCE   9
`define PACR_PC_AN_EN        7
`define PACR_PC_SPEED        6
`define PACR_PC_DUPLEX       5
`define PACR_PC_ADV_PAUSE    4
`define PACR_PC_ADV_ABIL_HI  3
`define PACR_PC_ADV_ABIL_LO  0

// reset values
`define PACR_RST_ADV_PAUSE   1'b1
`define PACR_RST_ADV_ABIL    4'hF
`define PACR_RST_AN_EN       1'b1
`define PACR_RST_SPEED       1'b1
`define PACR_RST_DUPLEX      1'b1

// cable result codes
`define PACR_CT_NORMAL       2'h0
`define PACR_CT_OPEN         2'h1
`define PACR_CT_SHORT        2'h2
`define PACR_CT_FAILED       2'h3

// cable test watchdog
`define PACR_CLK_NS          25
`define PACR_DIAG_LIMIT_US   100
`define PACR_DIAG_LIMIT_CYC  ((`PACR_DIAG_LIMIT_US * 1000) / `PACR_CLK_NS)

`endif

// file: core/pacr_pkg.sv
// types shared by the phy port register bank
package pacr_pkg;

  // advertised or partner abilities: pause plus 100f/100h/10f/10h
  typedef struct packed {
    logic       pause;
    logic [3:0] abil;
  } pacr_abil_t;

  // control word handed to the phy core
  typedef struct packed {
    logic led_off;
    logic tx_disable;
    logic restart_bit;
    logic mdix_auto_off;
    logic mdix_force;
    logic an_enable;
    logic speed_100;
    logic full_duplex;
    logic force_link;
    logic remote_loop;
  } pacr_ctrl_t;

  // cable diagnostic sequencer states
  typedef enum logic [0:0] {
    PACR_DIAG_IDLE,
    PACR_DIAG_RUN
  } pacr_diag_state_t;

endpackage

// file: core/pacr_cable_diag.sv
// cable diagnostic sequencer: runs one test and holds its result
`timescale 1ns/10ps
`include "pacr_params.svh"
module pacr_cable_diag
  import pacr_pkg::*;
#(
  parameter int unsigned LIMIT_CYC = `PACR_DIAG_LIMIT_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       diag_done,
  input  wire logic [1:0] diag_result,
  input  wire logic [8:0] diag_count,
  output logic            busy,
  output logic [1:0]      result,
  output logic [8:0]      count,
  output logic            diag_run
);

  pacr_diag_state_t state_reg;
  logic [15:0]      timer_reg;

  wire timed_out = (timer_reg == 16'(LIMIT_CYC - 1));

  // the analog engine may hang; the watchdog turns that into a failed test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PACR_DIAG_IDLE;
      timer_reg <= 16'h0000;
      result    <= `PACR_CT_NORMAL;
      count     <= 9'h000;
    end else begin
      unique case (state_reg)
        PACR_DIAG_IDLE: begin
          timer_reg <= 16'h0000;
          if (start) begin
            state_reg <= PACR_DIAG_RUN;
          end
        end
        PACR_DIAG_RUN: begin
          timer_reg <= timer_reg + 16'h0001;
          if (diag_done) begin
            state_reg <= PACR_DIAG_IDLE;
            result    <= diag_result;
            count     <= diag_count;
          end else if (timed_out) begin
            state_reg <= PACR_DIAG_IDLE;
            result    <= `PACR_CT_FAILED;
            count     <= 9'h000;
          end
        end
      endcase
    end
  end

  // busy and run follow the state, so the enable bit self-clears on completion
  assign busy     = (state_reg == PACR_DIAG_RUN);
  assign diag_run = (state_reg == PACR_DIAG_RUN);

endmodule

// file: tb/pacr_regs_assertions.sv
// concurrent checks on the ports of the phy port register bank
`timescale 1ns/10ps
`include "pacr_params.svh"
module pacr_regs_assertions
  import pacr_pkg::*;
#(
  parameter int unsigned ADDR_W    = 12,
  parameter int unsigned LIMIT_CYC = 20
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire pacr_abil_t        partner_in,
  input wire logic [3:0]        led_in,
  input wire logic              diag_done,
  input wire pacr_ctrl_t        ctrl,
  input wire pacr_abil_t        partner,
  input wire logic              mdix_x_mode,
  input wire logic              an_restart,
  input wire logic [3:0]        port_led,
  input wire logic              diag_run
);
  // the watchdog may end a run a cycle late, so allow two spare cycles
  localparam int DIAG_MAX = LIMIT_CYC + 2;
  localparam logic [ADDR_W-1:0] PC_ADDR = ADDR_W'(`PACR_IDX_PORT_CTRL * 4);
  localparam logic [ADDR_W-1:0] SC_ADDR = ADDR_W'(`PACR_IDX_SPECIAL * 4);

  // decoded write completions and the wanted crossover state
  wire logic wr_done   = psel && penable && pready && pwrite && pstrb[1];
  wire logic mdix_want = ctrl.mdix_auto_off & ctrl.mdix_force;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_one_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after exactly one wait state");
  a_unmapped_error: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response without ready or with data");
  a_led_off_high: assert property (ctrl.led_off && $past(ctrl.led_off) |-> port_led == 4'hF)
    else $error("leds not driven high while off");
  a_led_follow: assert property (!ctrl.led_off && !$past(ctrl.led_off) && $past(presetn) |->
    port_led == $past(led_in))
    else $error("leds do not follow the phy core");
  a_mdix_gate: assert property ($past(presetn) |-> mdix_x_mode == $past(mdix_want))
    else $error("mdi-x mode not gated by crossover disable");
  a_restart_pulse: assert property (wr_done && paddr == PC_ADDR && pwdata[`PACR_PC_RESTART] |=>
    an_restart ##1 !an_restart)
    else $error("restart pulse missing or too long");
  a_restart_cause: assert property (an_restart |->
    $past(wr_done && paddr == PC_ADDR && pwdata[`PACR_PC_RESTART]))
    else $error("restart pulse without a write");
  a_partner_mirror: assert property ($past(presetn) |-> partner == $past(partner_in))
    else $error("partner abilities not mirrored");
  // a start while busy is refused, so only an idle write must start a test
  a_diag_start: assert property (!diag_run && wr_done && paddr == SC_ADDR && pwdata[`PACR_SC_TEST_EN] |=>
    diag_run)
    else $error("cable test did not start");
  a_diag_done_end: assert property (diag_run && diag_done |=> !diag_run)
    else $error("cable test did not end on done");
  a_diag_bounded: assert property ($rose(diag_run) |-> ##[1:DIAG_MAX] !diag_run)
    else $error("cable test ran past its watchdog");
endmodule

bind pacr_regs pacr_regs_assertions #(.ADDR_W(ADDR_W), .LIMIT_CYC(LIMIT_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .partner_in(partner_in), .led_in(led_in), .diag_done(diag_done),
  .ctrl(ctrl), .partner(partner), .mdix_x_mode(mdix_x_mode), .an_restart(an_restart),
  .port_led(port_led), .diag_run(diag_run));

// file: tb/testbench.sv
// self-checking bench for the phy port register bank
`timescale 1ns/10ps
`include "pacr_params.svh"
module testbench;
  import pacr_pkg::*;
  localparam logic [15:0] ID_LO = 16'h5A3C; // arbitrary value
  localparam logic [15:0] ID_HI = 16'h00A5; // arbitrary value
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        diag_done, mdix_x_mode, an_restart, diag_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, led_in, port_led, strb_sel;
  logic [1:0]  diag_result;
  logic [8:0]  diag_count;
  pacr_abil_t  partner_in, advertise, partner;
  pacr_ctrl_t  ctrl;
  int          num_errors, total_checks;

  pacr_regs #(.ID_LOW(ID_LO), .ID_HIGH(ID_HI), .LIMIT_CYC(20)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .partner_in(partner_in), .led_in(led_in), .diag_done(diag_done),
    .diag_result(diag_result), .diag_count(diag_count), .ctrl(ctrl), .advertise(advertise),
    .partner(partner), .mdix_x_mode(mdix_x_mode), .an_restart(an_restart),
    .port_led(port_led), .diag_run(diag_run));

  // 40 mhz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic report_and_stop;
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; ready is awaited, never assumed
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    pstrb   <= strb_sel;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [15:0] exp, input string what);
    apb(1'b0, idx, 16'h0000);
    chk(what, {16'h0000, exp}, rd);
  endtask

  // reset values, identity words and an unmapped slot
  task automatic t_reset;
    rchk(`PACR_IDX_ID_LOW, ID_LO, "id_low");
    rchk(`PACR_IDX_ID_HIGH, ID_HI, "id_high");
    rchk(`PACR_IDX_ADVERTISE, 16'h05E1, "adv_rst");
    rchk(`PACR_IDX_PARTNER, 16'h0001, "lp_rst");
    rchk(`PACR_IDX_SPECIAL, 16'h0000, "sc_rst");
    rchk(`PACR_IDX_PORT_CTRL, 16'h00FF, "pc_rst");
    chk("ctrl_rst", 32'h01C, ctrl);
    chk("adv_out_rst", 32'h1F, advertise);
    apb(1'b1, 8'hF0, 16'hFFFF);
    rchk(8'hF0, 16'h0000, "unmapped");
    chk("unmapped_err", 32'h1, err);
  endtask

  // advertisement and port control share the ability flops
  task automatic t_alias;
    apb(1'b1, `PACR_IDX_ADVERTISE, 16'hFFFF);
    rchk(`PACR_IDX_ADVERTISE, 16'h05E1, "adv_ro");
    apb(1'b1, `PACR_IDX_ADVERTISE, 16'h0000);
    rchk(`PACR_IDX_ADVERTISE, 16'h0001, "adv_clr");
    rchk(`PACR_IDX_PORT_CTRL, 16'h00E0, "pc_alias");
    chk("adv_out_clr", 32'h00, advertise);
    apb(1'b1, `PACR_IDX_PORT_CTRL, 16'h00F5);
    rchk(`PACR_IDX_ADVERTISE, 16'h04A1, "adv_alias");
    chk("adv_out", 32'h15, advertise);
  endtask

  // led, transmit, crossover, forced mode and restart controls
  task automatic t_ctrl;
    apb(1'b1, `PACR_IDX_PORT_CTRL, 16'hDF1F);
    #1 chk("ctrl_on", 32'h360, ctrl);
    rchk(`PACR_IDX_PORT_CTRL, 16'hC61F, "pc_rsvd");
    chk("mdix_on", 32'h1, mdix_x_mode);
    chk("led_off", 32'hF, port_led);
    apb(1'b1, `PACR_IDX_PORT_CTRL, 16'h02E0);
    #1 chk("ctrl_an", 32'h03C, ctrl);
    rchk(`PACR_IDX_PORT_CTRL, 16'h02E0, "pc_an");
    chk("mdix_gate", 32'h0, mdix_x_mode);
    chk("led_on", 32'h5, port_led);
    apb(1'b1, `PACR_IDX_PORT_CTRL, 16'h20E0);
    #1 chk("restart", 32'h1, an_restart);
    @(posedge pclk);
    #1 chk("restart_end", 32'h0, an_restart);
    rchk(`PACR_IDX_PORT_CTRL, 16'h20E0, "pc_restart");
    // low lane only: stored restart one must not pulse, upper byte kept
    strb_sel = 4'h1;
    apb(1'b1, `PACR_IDX_PORT_CTRL, 16'h0000);
    strb_sel = 4'hF;
    #1 chk("restart_lane", 32'h0, an_restart);
    rchk(`PACR_IDX_PORT_CTRL, 16'h2000, "pc_lane");
  endtask

  // forced link and remote loopback, read-only fields untouched
  task automatic t_special;
    apb(1'b1, `PACR_IDX_SPECIAL, 16'hEFFF);
    #1 chk("sc_ctrl", 32'h3, {ctrl.force_link, ctrl.remote_loop});
    rchk(`PACR_IDX_SPECIAL, 16'h0A00, "sc_ro");
    apb(1'b1, `PACR_IDX_SPECIAL, 16'h0000);
    #1 chk("sc_clr", 32'h0, {ctrl.force_link, ctrl.remote_loop});
  endtask

  // every result code; the last one by letting the watchdog expire
  task automatic t_cable;
    logic [8:0] cnt;
    int n;
    for (int r = 0; r < 4; r++) begin
      cnt = (r == 3) ? 9'h000 : 9'h1FF - 9'(r);
      apb(1'b1, `PACR_IDX_SPECIAL, 16'h1000);
      #1 chk("diag_run", 32'h1, diag_run);
      if (r < 3) begin
        @(posedge pclk);
        diag_done   <= 1'b1;
        diag_result <= 2'(r);
        diag_count  <= cnt;
        @(posedge pclk);
        diag_done   <= 1'b0;
      end
      n = 0;
      do begin
        apb(1'b0, `PACR_IDX_SPECIAL, 16'h0000);
        n++;
      end while (rd[12] !== 1'b0 && n < 30);
      if (n >= 30) begin
        num_errors++;
        report_and_stop();
      end
      chk("diag_word", {16'h0000, 1'b0, 2'(r), 4'h0, cnt}, rd);
    end
  endtask

  // partner abilities reflected in the read view
  task automatic t_partner;
    @(posedge pclk);
    partner_in <= 5'h1A;
    rchk(`PACR_IDX_PARTNER, 16'h0541, "lp_word");
    chk("lp_out", 32'h1A, partner);
  endtask

  // reset, then the scenarios in turn
  initial begin
    num_errors = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    strb_sel = 4'hF;
    partner_in = 5'h00;
    led_in = 4'h5;
    diag_done = 1'b0;
    diag_result = 2'h0;
    diag_count = 9'h000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_alias();
    t_ctrl();
    t_special();
    t_cable();
    t_partner();
    report_and_stop();
  end
endmodule
